// *** rtl/scc_pkg.sv ***
// special character codec package: register map, character tables, types
// assumes 10-bit characters held in printed order, bit 9 = a, bit 0 = j
package scc_pkg;

  // register byte offsets
  localparam logic [3:0] SCC_REG_CTRL = 4'h0;
  localparam logic [3:0] SCC_REG_STATUS = 4'h4;
  localparam logic [3:0] SCC_REG_MASK = 4'h8;
  localparam logic [3:0] SCC_REG_STATE = 4'hC;

  // control fields
  localparam int SCC_CTRL_FRAMER_EN = 0;
  localparam int SCC_CTRL_FMT_LO = 8;
  localparam logic [7:0] SCC_FMT_RESET = 8'h00;

  // event bits of status and mask
  localparam int SCC_EV_W = 4;
  localparam int SCC_EV_COMMA = 0;
  localparam int SCC_EV_RX_RDERR = 1;
  localparam int SCC_EV_RX_VIOL = 2;
  localparam int SCC_EV_TX_IDLE = 3;

  // state register fields
  localparam int SCC_ST_TX_RD = 0;
  localparam int SCC_ST_RX_RD = 1;
  localparam int SCC_ST_LSB_PEND = 2;

  // forced bit of the character after an end-of-frame code (bit a)
  localparam int SCC_TX_LSB_POS = 9;

  // receive status field values
  localparam logic [2:0] SCC_RXST_DATA = 3'h0;
  localparam logic [2:0] SCC_RXST_SPECIAL = 3'h1;

  // special codes outside the table
  localparam logic [7:0] SCC_C_EOF = 8'h22;
  localparam logic [7:0] SCC_C_VIOL = 8'hE0;
  localparam logic [7:0] SCC_C_KNEG = 8'hE1;
  localparam logic [7:0] SCC_C_KPOS = 8'hE2;
  localparam logic [7:0] SCC_C_RDERR = 8'hE4;

  // table of twelve special characters; positive form is the complement
  localparam int SCC_K_N = 12;
  localparam int SCC_K28_5 = 5;
  localparam logic [9:0] SCC_K_RDN [SCC_K_N] = '{
    10'h0F4, 10'h0F9, 10'h0F5, 10'h0F3, 10'h0F2, 10'h0FA,
    10'h0F6, 10'h0F8, 10'h3A8, 10'h368, 10'h2E8, 10'h1E8};
  localparam logic [7:0] SCC_K_ALT [SCC_K_N] = '{
    8'h1C, 8'h3C, 8'h5C, 8'h7C, 8'h9C, 8'hBC,
    8'hDC, 8'hFC, 8'hF7, 8'hFB, 8'hFD, 8'hFE};
  localparam logic [9:0] SCC_VIOL_RDN = 10'h278;
  localparam logic [9:0] SCC_RDERR_RDN = 10'h375;

  // neutral character count of ones
  localparam logic [3:0] SCC_ONES_NEUTRAL = 4'h5;

  typedef struct packed {
    logic       special;
    logic [7:0] code;
  } scc_tx_char_t;

  typedef struct packed {
    logic [2:0] status;
    logic [7:0] code;
  } scc_rx_char_t;

endpackage : scc_pkg

// *** rtl/scc_disp.sv ***
// running disparity step for one 10-bit character
// assumes the character is already chosen; pure combinational
`timescale 1ns/10ps
`default_nettype none

module scc_disp (
  input wire logic [9:0] char_i, // transmission character
  input wire logic rd_i,         // running disparity before, 1 = plus
  output logic rd_o              // running disparity after
);
  import scc_pkg::*;

  logic [3:0] ones;

  always_comb begin
    ones = 4'h0;
    for (int i = 0; i < 10; i++) begin
      ones = ones + {3'h0, char_i[i]};
    end
    if (ones > SCC_ONES_NEUTRAL) begin
      rd_o = 1'b1;
    end else if (ones < SCC_ONES_NEUTRAL) begin
      rd_o = 1'b0;
    end else begin
      rd_o = rd_i;
    end
  end

endmodule : scc_disp

`default_nettype wire

// *** rtl/scc_codec.sv ***
// special character codec for one channel: transmit mapping, receive
// reporting, running disparity in both directions, avalon register slave
// assumes data-character tables sit outside and follow tx_rd_o / rx_rd_o;
// all character inputs come from logic on clk_sys_i, one character a cycle
`timescale 1ns/10ps
`default_nettype none

module scc_codec #(
  parameter int CHAN_IDX = 0 // which format select bit this channel uses
) (
  input wire logic clk_sys_i,                  // character clock
  input wire logic rst_b_i,                    // async reset, active low
  input wire logic [3:0] avs_address_i,        // byte address
  input wire logic avs_read_i,                 // read request
  input wire logic avs_write_i,                // write request
  input wire logic [31:0] avs_writedata_i,     // write data
  input wire logic [3:0] avs_byteenable_i,     // byte lanes
  output logic [31:0] avs_readdata_o,          // read data
  output logic avs_waitrequest_o,              // stall
  output logic irq_o,                          // level interrupt
  input wire logic tx_valid_i,                 // host character present
  input wire scc_pkg::scc_tx_char_t tx_char_i, // host character
  input wire logic tx_force_violation_i,       // send code violation
  input wire logic [9:0] tx_data_rdn_i,        // data char, RD- form
  input wire logic [9:0] tx_data_rdp_i,        // data char, RD+ form
  output logic tx_rd_o,                        // transmit RD, 1 = plus
  output logic [9:0] tx_code_o,                // transmission character
  output logic tx_idle_o,                      // idle fill was sent
  input wire logic rx_valid_i,                 // received character
  input wire logic [9:0] rx_code_i,            // received character
  input wire logic [7:0] rx_data_byte_i,       // data table result
  input wire logic rx_data_in_rdn_i,           // found in RD- column
  input wire logic rx_data_in_rdp_i,           // found in RD+ column
  output scc_pkg::scc_rx_char_t rx_char_o,     // decoded character
  output logic rx_valid_o,                     // decoded char strobe
  output logic rx_comma_o,                     // framing comma seen
  output logic rx_rd_o                         // receive RD, 1 = plus
);
  import scc_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // registers and bus slave

  logic framer_en_ff;
  logic [7:0] fmt_sel_ff;
  logic [SCC_EV_W-1:0] status_ff;
  logic [SCC_EV_W-1:0] mask_ff;
  logic [SCC_EV_W-1:0] events;
  logic ack_ff;
  logic req;
  logic wr_go;
  logic [31:0] nxt_readdata;
  logic tx_rd_ff;
  logic rx_rd_ff;
  logic lsb_pend_ff;
  logic fmt_alt;

  assign req = avs_read_i | avs_write_i;
  // one stall cycle lets read data come from a flip-flop
  assign avs_waitrequest_o = req & ~ack_ff;
  assign wr_go = avs_write_i & ack_ff;
  assign fmt_alt = fmt_sel_ff[CHAN_IDX];

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= req & ~ack_ff;
    end
  end

  always_comb begin
    nxt_readdata = 32'h0000_0000;
    if (avs_address_i == SCC_REG_CTRL) begin
      nxt_readdata[SCC_CTRL_FRAMER_EN] = framer_en_ff;
      nxt_readdata[SCC_CTRL_FMT_LO +: 8] = fmt_sel_ff;
    end else if (avs_address_i == SCC_REG_STATUS) begin
      nxt_readdata[SCC_EV_W-1:0] = status_ff;
    end else if (avs_address_i == SCC_REG_MASK) begin
      nxt_readdata[SCC_EV_W-1:0] = mask_ff;
    end else if (avs_address_i == SCC_REG_STATE) begin
      nxt_readdata[SCC_ST_TX_RD] = tx_rd_ff;
      nxt_readdata[SCC_ST_RX_RD] = rx_rd_ff;
      nxt_readdata[SCC_ST_LSB_PEND] = lsb_pend_ff;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (avs_read_i & ~ack_ff) begin
      avs_readdata_o <= nxt_readdata;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      framer_en_ff <= 1'b0;
      fmt_sel_ff <= SCC_FMT_RESET;
      mask_ff <= '0;
    end else if (wr_go) begin
      if (avs_address_i == SCC_REG_CTRL) begin
        if (avs_byteenable_i[0]) begin
          framer_en_ff <= avs_writedata_i[SCC_CTRL_FRAMER_EN];
        end
        if (avs_byteenable_i[1]) begin
          fmt_sel_ff <= avs_writedata_i[SCC_CTRL_FMT_LO +: 8];
        end
      end else if (avs_address_i == SCC_REG_MASK && avs_byteenable_i[0]) begin
        mask_ff <= avs_writedata_i[SCC_EV_W-1:0];
      end
    end
  end

  // new events win over a write-one clear in the same cycle
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      status_ff <= '0;
    end else if (wr_go && avs_address_i == SCC_REG_STATUS &&
                 avs_byteenable_i[0]) begin
      status_ff <= (status_ff & ~avs_writedata_i[SCC_EV_W-1:0]) | events;
    end else begin
      status_ff <= status_ff | events;
    end
  end

  assign irq_o = |(status_ff & mask_ff);

  ////////////////////////////////////////////////////////////////////////
  // transmit

  logic [9:0] nxt_tx_code;
  logic nxt_tx_rd;
  logic nxt_lsb_pend;
  logic tx_k_hit;
  int tx_k_idx;

  always_comb begin
    tx_k_hit = 1'b0;
    tx_k_idx = 0;
    for (int i = 0; i < SCC_K_N; i++) begin
      if (tx_char_i.code == 8'(i) || tx_char_i.code == SCC_K_ALT[i]) begin
        tx_k_hit = 1'b1;
        tx_k_idx = i;
      end
    end
  end

  always_comb begin
    nxt_lsb_pend = 1'b0;
    if (tx_force_violation_i) begin
      nxt_tx_code = tx_rd_ff ? ~SCC_VIOL_RDN : SCC_VIOL_RDN;
    end else if (!tx_valid_i) begin
      nxt_tx_code = tx_rd_ff ? ~SCC_K_RDN[SCC_K28_5] : SCC_K_RDN[SCC_K28_5];
    end else if (!tx_char_i.special) begin
      nxt_tx_code = tx_rd_ff ? tx_data_rdp_i : tx_data_rdn_i;
    end else if (tx_k_hit) begin
      nxt_tx_code = tx_rd_ff ? ~SCC_K_RDN[tx_k_idx] : SCC_K_RDN[tx_k_idx];
    end else begin
      case (tx_char_i.code)
        SCC_C_VIOL: begin
          nxt_tx_code = tx_rd_ff ? ~SCC_VIOL_RDN : SCC_VIOL_RDN;
        end
        SCC_C_KNEG: begin
          nxt_tx_code = SCC_K_RDN[SCC_K28_5];
        end
        SCC_C_KPOS: begin
          nxt_tx_code = ~SCC_K_RDN[SCC_K28_5];
        end
        SCC_C_RDERR: begin
          nxt_tx_code = tx_rd_ff ? ~SCC_RDERR_RDN : SCC_RDERR_RDN;
        end
        SCC_C_EOF: begin
          nxt_tx_code = tx_rd_ff ? ~SCC_K_RDN[SCC_K28_5]
                                 : SCC_K_RDN[SCC_K28_5];
          nxt_lsb_pend = 1'b1;
        end
        // reserved codes fall back to plain fill
        default: begin
          nxt_tx_code = tx_rd_ff ? ~SCC_K_RDN[SCC_K28_5]
                                 : SCC_K_RDN[SCC_K28_5];
        end
      endcase
    end
    // force bit by disparity at start
    if (lsb_pend_ff) begin
      nxt_tx_code[SCC_TX_LSB_POS] = ~tx_rd_ff;
    end
  end

  scc_disp u_tx_disp (
    .char_i(nxt_tx_code),
    .rd_i(tx_rd_ff),
    .rd_o(nxt_tx_rd)
  );

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tx_code_o <= 10'h000;
      tx_rd_ff <= 1'b0;
      lsb_pend_ff <= 1'b0;
      tx_idle_o <= 1'b0;
    end else begin
      tx_code_o <= nxt_tx_code;
      tx_rd_ff <= nxt_tx_rd;
      lsb_pend_ff <= nxt_lsb_pend;
      tx_idle_o <= ~tx_valid_i;
    end
  end

  assign tx_rd_o = tx_rd_ff;

  ////////////////////////////////////////////////////////////////////////
  // receive

  scc_rx_char_t nxt_rx_char;
  logic nxt_rx_rd;
  logic rx_k_hit;
  logic rx_k_neg;
  logic rx_is_comma;
  int rx_k_idx;

  always_comb begin
    rx_k_hit = 1'b0;
    rx_k_neg = 1'b0;
    rx_k_idx = 0;
    for (int i = 0; i < SCC_K_N; i++) begin
      if (rx_code_i == SCC_K_RDN[i] || rx_code_i == ~SCC_K_RDN[i]) begin
        rx_k_hit = 1'b1;
        rx_k_neg = (rx_code_i == SCC_K_RDN[i]);
        rx_k_idx = i;
      end
    end
    rx_is_comma = rx_k_hit && rx_k_idx == SCC_K28_5;
  end

  always_comb begin
    nxt_rx_char.status = SCC_RXST_SPECIAL;
    nxt_rx_char.code = SCC_C_VIOL;
    if (rx_k_hit) begin
      if (rx_is_comma && rx_k_neg && rx_rd_ff) begin
        nxt_rx_char.code = SCC_C_KNEG;
      end else if (rx_is_comma && !rx_k_neg && !rx_rd_ff) begin
        nxt_rx_char.code = SCC_C_KPOS;
      end else if (rx_k_neg == rx_rd_ff) begin
        nxt_rx_char.code = SCC_C_RDERR;
      end else begin
        nxt_rx_char.code = fmt_alt ? SCC_K_ALT[rx_k_idx] : 8'(rx_k_idx);
      end
    end else if (rx_data_in_rdn_i || rx_data_in_rdp_i) begin
      if (rx_rd_ff ? rx_data_in_rdp_i : rx_data_in_rdn_i) begin
        // data after a comma stays data
        nxt_rx_char.status = SCC_RXST_DATA;
        nxt_rx_char.code = rx_data_byte_i;
      end else begin
        nxt_rx_char.code = SCC_C_RDERR;
      end
    end
  end

  scc_disp u_rx_disp (
    .char_i(rx_code_i),
    .rd_i(rx_rd_ff),
    .rd_o(nxt_rx_rd)
  );

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rx_char_o <= '0;
      rx_valid_o <= 1'b0;
      rx_comma_o <= 1'b0;
      rx_rd_ff <= 1'b0;
    end else begin
      rx_valid_o <= rx_valid_i;
      rx_comma_o <= rx_valid_i & rx_is_comma & framer_en_ff;
      if (rx_valid_i) begin
        rx_char_o <= nxt_rx_char;
        rx_rd_ff <= nxt_rx_rd;
      end
    end
  end

  assign rx_rd_o = rx_rd_ff;

  always_comb begin
    events = '0;
    events[SCC_EV_COMMA] = rx_valid_i & rx_is_comma & framer_en_ff;
    events[SCC_EV_RX_RDERR] = rx_valid_i &
                              nxt_rx_char.code == SCC_C_RDERR;
    events[SCC_EV_RX_VIOL] = rx_valid_i & nxt_rx_char.code == SCC_C_VIOL &
                             nxt_rx_char.status == SCC_RXST_SPECIAL;
    events[SCC_EV_TX_IDLE] = ~tx_valid_i;
  end

  ////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);

  sequence s_plain_tx;
    !tx_force_violation_i && !lsb_pend_ff;
  endsequence

  sequence s_eof_taken;
    tx_valid_i && tx_char_i.special && tx_char_i.code == SCC_C_EOF &&
    !tx_force_violation_i && !lsb_pend_ff;
  endsequence

  a_idle_fill: assert property (
    s_plain_tx and !tx_valid_i |=>
      tx_code_o == ($past(tx_rd_ff) ? ~SCC_K_RDN[SCC_K28_5]
                                    : SCC_K_RDN[SCC_K28_5]))
    else $error("idle fill is not K28.5 of current disparity");

  a_alt_map_same: assert property (
    s_plain_tx and tx_valid_i && tx_char_i.special &&
    tx_char_i.code == SCC_K_ALT[0] |=>
      tx_code_o == ($past(tx_rd_ff) ? ~SCC_K_RDN[0] : SCC_K_RDN[0]))
    else $error("alternate code maps to wrong character");

  a_eof_lsb_force: assert property (
    s_eof_taken ##1 1'b1 |=>
      tx_code_o[SCC_TX_LSB_POS] == ~$past(tx_rd_ff))
    else $error("character after end of frame has wrong bit");

  a_viol_input: assert property (
    tx_force_violation_i |=>
      tx_code_o[SCC_TX_LSB_POS-1:0] ==
      ($past(tx_rd_ff) ? ~SCC_VIOL_RDN[SCC_TX_LSB_POS-1:0]
                       : SCC_VIOL_RDN[SCC_TX_LSB_POS-1:0]))
    else $error("forced violation pattern wrong");

  a_kneg_fixed: assert property (
    s_plain_tx and tx_valid_i && tx_char_i.special &&
    tx_char_i.code == SCC_C_KNEG |=> tx_code_o == SCC_K_RDN[SCC_K28_5])
    else $error("negative K28.5 not sent");

  a_kpos_fixed: assert property (
    s_plain_tx and tx_valid_i && tx_char_i.special &&
    tx_char_i.code == SCC_C_KPOS |=> tx_code_o == ~SCC_K_RDN[SCC_K28_5])
    else $error("positive K28.5 not sent");

  a_tx_rd_track: assert property (
    $countones(tx_code_o) > 5 |-> tx_rd_ff)
    else $error("transmit disparity not raised");

  a_rx_kneg_rep: assert property (
    rx_valid_i && rx_code_i == SCC_K_RDN[SCC_K28_5] && rx_rd_ff |=>
      rx_valid_o && rx_char_o.code == SCC_C_KNEG && rx_rd_ff)
    else $error("C1.7 not reported for negative comma at RD+");

  a_rx_kpos_rep: assert property (
    rx_valid_i && rx_code_i == ~SCC_K_RDN[SCC_K28_5] && !rx_rd_ff |=>
      rx_char_o.code == SCC_C_KPOS && !rx_rd_ff)
    else $error("C2.7 not reported for positive comma at RD-");

  a_rx_no_eof: assert property (
    rx_valid_o && rx_char_o.status == SCC_RXST_SPECIAL |->
      rx_char_o.code != SCC_C_EOF)
    else $error("receiver reported end of frame code");

  a_rx_rd_error: assert property (
    rx_valid_i && rx_data_in_rdp_i && !rx_data_in_rdn_i && !rx_k_hit &&
    !rx_rd_ff |=> rx_char_o.status == SCC_RXST_SPECIAL &&
    rx_char_o.code == SCC_C_RDERR)
    else $error("disparity mismatch not reported");

endmodule : scc_codec

`default_nettype wire

// *** verification/scc_host_model.sv ***
// host character source for the codec's transmit side, plus data table
// assumes the bench calls send() per character or sets stream for fill
`timescale 1ns/10ps
`default_nettype none

module scc_host_model (
  input wire logic clk_sys_i,                // character clock
  output logic tx_valid_o,                   // character present
  output scc_pkg::scc_tx_char_t tx_char_o,   // host character
  output logic tx_force_violation_o,         // violation request
  output logic [9:0] tx_data_rdn_o,          // data table, RD- form
  output logic [9:0] tx_data_rdp_o           // data table, RD+ form
);
  import scc_pkg::*;
  logic stream = 1'b0;
  integer seed = 32'hD30EEBA6;
  logic [7:0] last_sp = 8'h00;

  initial begin
    tx_valid_o = 1'b0;
    tx_char_o = '0;
    tx_force_violation_o = 1'b0;
    tx_data_rdn_o = '0;
    tx_data_rdp_o = '0;
  end

  // table lines change every cycle so a stale value never passes
  always @(posedge clk_sys_i) begin
    tx_data_rdn_o <= 10'($random(seed));
    tx_data_rdp_o <= 10'($random(seed));
    if (stream) begin
      tx_valid_o <= 1'b1;
      tx_char_o <= {1'b0, 8'($random(seed))};
      tx_force_violation_o <= 1'b0;
    end
  end

  task automatic send(input logic sp, input logic [7:0] code,
                      input logic vi, input logic vld);
    logic [7:0] c;
    c = code;
    if (!sp && (last_sp == SCC_C_VIOL || last_sp == 8'h07 ||
                last_sp == SCC_K_ALT[7]) &&
        (c[4:0] == 5'h0B || c[4:0] == 5'h14))
      c[0] = ~c[0];
    @(posedge clk_sys_i);
    tx_valid_o <= vld;
    tx_char_o <= {sp, c};
    tx_force_violation_o <= vi;
    // a forced violation aliases a comma just like the code does
    last_sp = vi ? SCC_C_VIOL : (sp && vld) ? c : 8'h00;
  endtask : send
endmodule : scc_host_model
`default_nettype wire

// *** verification/scc_codec_bench.sv ***
// self-checking bench: behavioural codec model compared every cycle
// assumes scc_host_model feeds transmit; bench drives receive and bus
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  failures++; $display("unexpected %s exp %h got %h", n, e, g); end end

module scc_codec_bench;
  import scc_pkg::*;
  localparam int CH = 2;
  localparam logic [7:0] TXC [5] = '{SCC_C_VIOL, SCC_C_KNEG, SCC_C_KPOS,
    SCC_C_RDERR, SCC_C_EOF};
  logic clk_sys_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [3:0] avs_address_i = '0;
  logic avs_read_i = 1'b0, avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = '0, avs_readdata_o, q, mctl = '0;
  logic avs_waitrequest_o, irq_o, tx_valid_i, tx_force_violation_i;
  scc_tx_char_t tx_char_i;
  logic [9:0] tx_data_rdn_i, tx_data_rdp_i, tx_code_o, ecode;
  logic [9:0] rx_code_i = '0;
  logic tx_rd_o, tx_idle_o, rx_valid_o, rx_comma_o, rx_rd_o;
  logic rx_valid_i = 1'b0, rx_data_in_rdn_i = 1'b0, rx_data_in_rdp_i = 1'b0;
  logic [7:0] rx_data_byte_i = '0;
  scc_rx_char_t rx_char_o, erx;
  integer seed = 32'hD30EEBA6;
  int failures = 0, samples_checked = 0;
  logic [3:0] mmask = '0, mst = '0;
  logic mtrd, mrrd, pend, eidle, ev, ecm, armed = 1'b0;

  initial forever #2 clk_sys_i = ~clk_sys_i;

  scc_codec #(.CHAN_IDX(CH)) scc_codec_i (.clk_sys_i, .rst_b_i,
    .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
    .avs_byteenable_i(4'hF), .avs_readdata_o, .avs_waitrequest_o, .irq_o,
    .tx_valid_i, .tx_char_i, .tx_force_violation_i, .tx_data_rdn_i,
    .tx_data_rdp_i, .tx_rd_o, .tx_code_o, .tx_idle_o, .rx_valid_i,
    .rx_code_i, .rx_data_byte_i, .rx_data_in_rdn_i, .rx_data_in_rdp_i,
    .rx_char_o, .rx_valid_o, .rx_comma_o, .rx_rd_o);
  scc_host_model scc_host_model_i (.clk_sys_i, .tx_valid_o(tx_valid_i),
    .tx_char_o(tx_char_i), .tx_force_violation_o(tx_force_violation_i),
    .tx_data_rdn_o(tx_data_rdn_i), .tx_data_rdp_o(tx_data_rdp_i));

  function automatic logic nrd(input logic [9:0] c, input logic rd);
    return ($countones(c) > 5) ? 1'b1 : ($countones(c) < 5) ? 1'b0 : rd;
  endfunction : nrd

  function automatic logic [9:0] tx_exp(input scc_tx_char_t t,
                                        input logic v, vi, rd);
    logic [9:0] n;
    n = SCC_K_RDN[SCC_K28_5];
    if (v && t.special) begin
      for (int i = 0; i < SCC_K_N; i++)
        if (t.code == 8'(i) || t.code == SCC_K_ALT[i]) n = SCC_K_RDN[i];
      if (t.code == SCC_C_VIOL) n = SCC_VIOL_RDN;
      if (t.code == SCC_C_RDERR) n = SCC_RDERR_RDN;
    end
    if (vi) return rd ? ~SCC_VIOL_RDN : SCC_VIOL_RDN;
    if (v && !t.special) return rd ? tx_data_rdp_i : tx_data_rdn_i;
    if (v && t.code == SCC_C_KNEG) return n;
    if (v && t.code == SCC_C_KPOS) return ~n;
    return rd ? ~n : n;
  endfunction : tx_exp

  ////////////////////////////////////////////////////////////////////
  always @(posedge clk_sys_i) begin : model
    logic [9:0] e;
    logic [7:0] rc;
    logic [2:0] rs;
    logic kf, cm;
    if (!rst_b_i) begin
      {mtrd, mrrd, pend, mst, mctl, erx, ev, ecm} = '0;
      armed = 1'b0;
    end else begin
      e = tx_exp(tx_char_i, tx_valid_i, tx_force_violation_i, mtrd);
      if (pend) e[SCC_TX_LSB_POS] = ~mtrd;
      pend = tx_valid_i && tx_char_i.special && !tx_force_violation_i &&
             tx_char_i.code == SCC_C_EOF;
      ecode = e;
      eidle = !tx_valid_i;
      mtrd = nrd(e, mtrd);
      if (eidle) mst[3] = 1'b1;
      ev = rx_valid_i;
      ecm = 1'b0;
      if (rx_valid_i) begin
        rs = SCC_RXST_SPECIAL;
        rc = SCC_C_VIOL;
        kf = 1'b0;
        cm = 1'b0;
        for (int i = 0; i < SCC_K_N; i++)
          if (rx_code_i == SCC_K_RDN[i] || rx_code_i == ~SCC_K_RDN[i]) begin
            kf = 1'b1;
            cm = (i == SCC_K28_5);
            rc = ((rx_code_i == SCC_K_RDN[i]) != mrrd) ?
                 (mctl[8 + CH] ? SCC_K_ALT[i] : 8'(i)) : SCC_C_RDERR;
          end
        if (cm && rc == SCC_C_RDERR) rc = mrrd ? SCC_C_KNEG : SCC_C_KPOS;
        if (!kf && ((rx_data_in_rdn_i && !mrrd) ||
                    (rx_data_in_rdp_i && mrrd))) begin
          rs = SCC_RXST_DATA;
          rc = rx_data_byte_i;
        end else if (!kf && (rx_data_in_rdn_i || rx_data_in_rdp_i))
          rc = SCC_C_RDERR;
        erx = {rs, rc};
        ecm = cm && mctl[0];
        mrrd = nrd(rx_code_i, mrrd);
        if (ecm) mst[0] = 1'b1;
        if (rs == SCC_RXST_SPECIAL && rc == SCC_C_RDERR) mst[1] = 1'b1;
        if (rs == SCC_RXST_SPECIAL && rc == SCC_C_VIOL) mst[2] = 1'b1;
      end
      armed = 1'b1;
    end
  end

  always @(negedge clk_sys_i) begin
    if (armed && rst_b_i) begin
      `CHK("tx_code_o", ecode, tx_code_o)
      `CHK("tx_rd_o", mtrd, tx_rd_o)
      `CHK("tx_idle_o", eidle, tx_idle_o)
      `CHK("rx_valid_o", ev, rx_valid_o)
      `CHK("rx_char_o", erx, rx_char_o)
      `CHK("rx_comma_o", ecm, rx_comma_o)
      `CHK("rx_rd_o", mrrd, rx_rd_o)
      `CHK("irq_o", |(mst & mmask), irq_o)
    end
  end

  ////////////////////////////////////////////////////////////////////
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d, output logic [31:0] rq);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 50);
    if (n >= 50) failures++;
    rq = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    if (wr && a == SCC_REG_CTRL) mctl = d & 32'h0000FF01;
    if (wr && a == SCC_REG_MASK) mmask = d[3:0];
    if (wr && a == SCC_REG_STATUS) mst = mst & ~d[3:0];
  endtask : bus

  task automatic tx_run(input int n);
    int s;
    logic [31:0] a;
    logic [7:0] k;
    for (int j = 0; j < n; j++) begin
      s = $unsigned($random(seed)) % 20;
      a = $random(seed);
      k = (s < 12) ? (a[0] ? SCC_K_ALT[s] : 8'(s)) : a[15:8];
      if (s > 11 && s < 17) k = TXC[s - 12];
      scc_host_model_i.send(s < 17, k, s > 17 && a[1] && a[4:2] != 0,
                            a[4:2] != 0);
    end
    scc_host_model_i.send(1'b0, 8'h00, 1'b0, 1'b0);
  endtask : tx_run

  task automatic rx_run(input int n);
    int s;
    logic [31:0] a;
    for (int j = 0; j < n; j++) begin
      s = $unsigned($random(seed)) % 16;
      a = $random(seed);
      s = (s < 12) ? s : (s < 14) ? SCC_K28_5 : 12;
      @(posedge clk_sys_i);
      rx_valid_i <= a[5:3] != 0;
      rx_code_i <= (s < 12) ? (a[0] ? ~SCC_K_RDN[s] : SCC_K_RDN[s]) :
                   {2'b10, a[23:17], 1'b1};
      rx_data_in_rdn_i <= s == 12 && a[6];
      rx_data_in_rdp_i <= s == 12 && a[7];
      rx_data_byte_i <= a[15:8];
    end
    @(posedge clk_sys_i);
    rx_valid_i <= 1'b0;
  endtask : rx_run

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : print_verdict

  initial begin
    repeat (8) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      scc_host_model_i.stream = 1'b1;
      repeat (2) @(posedge clk_sys_i);
      bus(1'b1, 4'h2, 32'hFFFFFFFF, q);
      bus(1'b0, 4'h2, 32'h0, q);
      `CHK("unmapped", 32'h0, q)
      bus(1'b0, SCC_REG_CTRL, 32'h0, q);
      `CHK("ctrl", mctl, q)
      bus(1'b0, SCC_REG_MASK, 32'h0, q);
      `CHK("mask", {28'h0, mmask}, q)
      bus(1'b0, SCC_REG_STATUS, 32'h0, q);
      `CHK("status", {28'h0, mst}, q)
      // tx disparity can move on any cycle here, so bit 0 is left out
      bus(1'b0, SCC_REG_STATE, 32'h0, q);
      `CHK("state", {29'h0, pend, mrrd}, q[31:1])
      if (k == 2) print_verdict();
      bus(1'b1, SCC_REG_CTRL, k ? 32'h1 : 32'h400, q);
      bus(1'b1, SCC_REG_MASK, k ? 32'hF : 32'h6, q);
      bus(1'b1, SCC_REG_STATUS, 32'hF, q);
      scc_host_model_i.stream = 1'b0;
      fork
        tx_run(300);
        rx_run(300);
      join
    end
  end

  initial begin
    repeat (6000) @(posedge clk_sys_i);
    failures++;
    print_verdict();
  end
endmodule : scc_codec_bench
`default_nettype wire
